/* cpre_pkg.sv */
// constants and types shared by the current/power result engine
//------------------------------------------------------------------
// What this block does
// [R1] rail code weight fixed, independent of scaling
// [R2] rail result top bit always reads zero
// [R3] power equals current times rail over 20000
// [R4] power step is 25 current steps
// [R5] current equals shunt times scale over 2048
// [R6] current and power need a loaded scale
// [R7] unscaled current and power stay zero
// [R8] reset setup selects continuous shunt and rail
// [R9] all registers reload defaults on reset
// [R10] master owns clock, access, start, stop
// [R11] start is data falling while clock high
// [R12] address sampled on rise, bit eight direction
// [R13] addressed device pulls data low ninth pulse
// [R14] eight bits plus acknowledge, change clock low
// [R15] data change during clock high is start/stop
// [R16] stop is data rising while clock high
// [R17] stalled transaction released after 28 ms
// [R18] pins only pull low or release
// [R19] write is address, pointer, two data bytes
// [R20] sixteen-bit values go high byte first
// [R21] truncate toward zero, recompute per conversion
// [R22] result registers ignore writes but acknowledge
//------------------------------------------------------------------
package cpre_pkg;
  // register pointers
  localparam logic [7:0] PTR_SETUP   = 8'h00;
  localparam logic [7:0] PTR_SHUNT   = 8'h01;
  localparam logic [7:0] PTR_RAIL    = 8'h02;
  localparam logic [7:0] PTR_POWER   = 8'h03;
  localparam logic [7:0] PTR_CURRENT = 8'h04;
  localparam logic [7:0] PTR_SCALE   = 8'h05;
  // reset values; setup default runs shunt and rail continuously
  localparam logic [15:0] SETUP_RST = 16'h4127;
  localparam logic [15:0] ZERO_RST  = 16'h0000;
  // arithmetic
  localparam logic signed [32:0] CUR_DIV = 33'sh0_0000_0800;
  localparam logic [31:0]        PWR_DIV = 32'h0000_4e20;
  // bus
  localparam logic [6:0] DEV_ADDR  = 7'h40;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  // timing
  localparam int CLK_HZ  = 25_000_000;
  localparam int TMO_MS  = 28;
  localparam int TMO_CYC = CLK_HZ / 1000 * TMO_MS;
  // bus engine phases and byte positions
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK
  } cpre_st_t;
  typedef enum logic [1:0] {
    BY_ADDR, BY_PTR, BY_MSB, BY_LSB
  } cpre_byte_t;
endpackage

/* cpre_res_if.sv */
// interface between the bus/register logic and the result engine
`timescale 1ns/100ps
`default_nettype none
interface cpre_res_if;
  logic        conv_done;
  logic [15:0] shunt_in;
  logic [15:0] rail_in;
  logic [15:0] scale;
  logic        scale_set;
  logic [15:0] shunt;
  logic [15:0] rail;
  logic [15:0] current;
  logic [15:0] power;
  modport regs (output conv_done, shunt_in, rail_in, scale, scale_set,
                input shunt, rail, current, power);
  modport engine (input conv_done, shunt_in, rail_in, scale, scale_set,
                  output shunt, rail, current, power);
endinterface // cpre_res_if
`default_nettype wire

/* cpre_calc.sv */
// result engine: latches conversions and scales current and power
`timescale 1ns/100ps
`default_nettype none
module cpre_calc (
  // clock and synchronised reset
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  // results and their sources
  cpre_res_if.engine  res
);
  logic [15:0]        shunt_r, rail_r, cur_r, pwr_r;
  logic [15:0]        shunt_nxt, rail_nxt, cur_nxt, pwr_nxt;
  logic signed [32:0] prod, quo;
  logic [15:0]        cur16;
  logic [16:0]        mag;
  logic [31:0]        pprod, pquo;

  // recompute both results from the fresh pair in the cycle it lands
  always_comb begin
    shunt_nxt = shunt_r;
    rail_nxt  = rail_r;
    cur_nxt   = cur_r;
    pwr_nxt   = pwr_r;
    // signed division truncates toward zero, a shift would floor
    prod  = $signed(res.shunt_in) * $signed({1'b0, res.scale});  // [R5]
    quo   = prod / cpre_pkg::CUR_DIV;                             // [R21]
    cur16 = quo[15:0];
    mag   = cur16[15] ? 17'({1'b0, ~cur16} + 17'h0_0001) : {1'b0, cur16};
    // rail code passes unscaled; power step is 25 current steps
    pprod = mag * res.rail_in[14:0];                      // [R1] [R4]
    pquo  = pprod / cpre_pkg::PWR_DIV;                    // [R3]
    if (res.conv_done) begin                              // [R21]
      shunt_nxt = res.shunt_in;
      rail_nxt  = {1'b0, res.rail_in[14:0]};              // [R2]
      cur_nxt   = res.scale_set ? cur16 : cpre_pkg::ZERO_RST;     // [R7]
      pwr_nxt   = res.scale_set ? pquo[15:0] : cpre_pkg::ZERO_RST; // [R6]
    end
  end

  // result registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shunt_r <= cpre_pkg::ZERO_RST;                      // [R9]
      rail_r  <= cpre_pkg::ZERO_RST;
      cur_r   <= cpre_pkg::ZERO_RST;
      pwr_r   <= cpre_pkg::ZERO_RST;
    end else begin
      shunt_r <= shunt_nxt;
      rail_r  <= rail_nxt;
      cur_r   <= cur_nxt;
      pwr_r   <= pwr_nxt;
    end
  end

  assign res.shunt   = shunt_r;
  assign res.rail    = rail_r;
  assign res.current = cur_r;
  assign res.power   = pwr_r;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [16:0] cmag;
  assign cmag = cur_r[15] ? 17'({1'b0, ~cur_r} + 17'h0_0001)
                          : {1'b0, cur_r};

  rail_msb_a: assert property (!res.rail[15])                  // [R2]
    else $error("rail result top bit set");
  unscaled_zero_a: assert property (                           // [R7]
    !res.scale_set |-> res.current == 16'h0000 && res.power == 16'h0000)
    else $error("result nonzero without scale");
  current_scale_a: assert property (                           // [R5]
    res.conv_done && res.scale_set |=>
      $signed(res.current) == $signed(16'(($signed($past(res.shunt_in))
        * $signed({1'b0, $past(res.scale)})) / 33'sh0_0000_0800)))
    else $error("current result mismatch");
  power_bound_a: assert property (                             // [R3]
    $past(res.conv_done) && res.scale_set |->
      ({16'h0000, res.power} * 32'h0000_4e20 <= cmag * res.rail[14:0])
      && (cmag * res.rail[14:0] < ({16'h0000, res.power} + 32'h1)
        * 32'h0000_4e20))
    else $error("power result out of range");
  result_hold_a: assert property (                             // [R21]
    !res.conv_done |=> $stable(res.current) && $stable(res.power))
    else $error("result changed without conversion");
  scaled_conv_c: cover property (res.conv_done && res.scale_set);
  neg_current_c: cover property (res.scale_set && res.current[15]);
endmodule // cpre_calc
`default_nettype wire

/* cpre_top.sv */
// two-wire slave, register file and result engine of the monitor
`timescale 1ns/100ps
`default_nettype none
module cpre_top #(
  parameter int TMO_CYCLES = cpre_pkg::TMO_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // two-wire bus pins, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  // converter side
  input  wire logic [15:0] shunt_code_i,
  input  wire logic [15:0] rail_code_i,
  input  wire logic        conv_done_i,
  output logic      [15:0] setup_o
);
  localparam int TW = $clog2(TMO_CYCLES + 1);

  //------------------------------------------------------------
  // reset release and pin synchronisers
  //------------------------------------------------------------
  logic rst_q, rst_n;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;

  // reset releases two edges after the pin rises
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q <= 1'b1;
      rst_n <= rst_q;
    end
  end

  // first stages feed only the second; idle bus reads high
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  // any data edge while clock stays high is start or stop
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;      // [R11] [R15]
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;      // [R16] [R15]

  //------------------------------------------------------------
  // bus engine
  //------------------------------------------------------------
  cpre_pkg::cpre_st_t   st_r, st_nxt;
  cpre_pkg::cpre_byte_t by_r, by_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  sh_r, sh_nxt, msb_r, msb_nxt, ptr_r, ptr_nxt;
  logic [15:0] rd_r, rd_nxt, rd_val;
  logic        rw_r, rw_nxt, drv_r, drv_nxt, lsb_r, lsb_nxt;
  logic        ack_r, ack_nxt, wr_go, tmo_hit;
  logic [TW-1:0] tmo_r, tmo_nxt;
  logic [7:0]  nb;
  logic [15:0] setup_r, setup_nxt, scale_r, scale_nxt;
  logic        set_r, set_nxt;

  cpre_res_if res ();

  // read mux; unmapped pointers read zero
  always_comb begin
    unique case (ptr_r)
      cpre_pkg::PTR_SETUP:   rd_val = setup_r;
      cpre_pkg::PTR_SHUNT:   rd_val = res.shunt;
      cpre_pkg::PTR_RAIL:    rd_val = res.rail;
      cpre_pkg::PTR_POWER:   rd_val = res.power;
      cpre_pkg::PTR_CURRENT: rd_val = res.current;
      cpre_pkg::PTR_SCALE:   rd_val = scale_r;
      default:               rd_val = cpre_pkg::ZERO_RST;
    endcase
  end

  // next bus state; start and stop win over any phase
  always_comb begin
    st_nxt  = st_r;
    by_nxt  = by_r;
    bit_nxt = bit_r;
    sh_nxt  = sh_r;
    msb_nxt = msb_r;
    ptr_nxt = ptr_r;
    rd_nxt  = rd_r;
    rw_nxt  = rw_r;
    drv_nxt = drv_r;
    lsb_nxt = lsb_r;
    ack_nxt = ack_r;
    wr_go   = 1'b0;
    // high byte first, then low, then high again on repeated reads
    nb      = lsb_r ? rd_r[7:0] : rd_r[15:8];             // [R20]
    // the stall clock restarts on every clock edge of the bus
    tmo_hit = (tmo_r == TW'(TMO_CYCLES));
    if (st_r == cpre_pkg::ST_IDLE || scl_rise || scl_fall)
      tmo_nxt = '0;
    else
      tmo_nxt = TW'(tmo_r + 1'b1);
    if (start_det) begin                                  // [R11]
      st_nxt  = cpre_pkg::ST_RX;
      by_nxt  = cpre_pkg::BY_ADDR;
      bit_nxt = '0;
      drv_nxt = 1'b0;
    end else if (stop_det || tmo_hit) begin               // [R16] [R17]
      st_nxt  = cpre_pkg::ST_IDLE;
      drv_nxt = 1'b0;
    end else begin
      unique case (st_r)
        cpre_pkg::ST_IDLE: ;
        cpre_pkg::ST_RX: begin
          if (scl_rise) begin                             // [R12]
            sh_nxt  = {sh_r[6:0], sda_s};
            bit_nxt = bit_r + 4'h1;
          end else if (scl_fall && bit_r == cpre_pkg::BITS_BYTE) begin
            bit_nxt = '0;
            if (by_r == cpre_pkg::BY_ADDR) begin
              if (sh_r[7:1] == cpre_pkg::DEV_ADDR) begin
                st_nxt  = cpre_pkg::ST_ACK;
                drv_nxt = 1'b1;                           // [R13]
                rw_nxt  = sh_r[0];                        // [R12]
                rd_nxt  = rd_val;
                lsb_nxt = 1'b0;
                by_nxt  = cpre_pkg::BY_PTR;
              end else begin
                st_nxt  = cpre_pkg::ST_IDLE;
              end
            end else begin
              st_nxt  = cpre_pkg::ST_ACK;                 // [R14]
              drv_nxt = 1'b1;
              unique case (by_r)                          // [R19]
                cpre_pkg::BY_PTR: begin
                  ptr_nxt = sh_r;
                  by_nxt  = cpre_pkg::BY_MSB;
                end
                cpre_pkg::BY_MSB: begin
                  msb_nxt = sh_r;                         // [R20]
                  by_nxt  = cpre_pkg::BY_LSB;
                end
                default: begin
                  wr_go   = 1'b1;
                  by_nxt  = cpre_pkg::BY_MSB;
                end
              endcase
            end
          end
        end
        cpre_pkg::ST_ACK: if (scl_fall) begin             // [R14]
          if (rw_r) begin
            st_nxt  = cpre_pkg::ST_TX;
            sh_nxt  = nb;
            drv_nxt = ~nb[7];
            lsb_nxt = ~lsb_r;
          end else begin
            st_nxt  = cpre_pkg::ST_RX;
            drv_nxt = 1'b0;
          end
        end
        cpre_pkg::ST_TX: if (scl_fall) begin              // [R14]
          if (bit_r == cpre_pkg::BIT_LAST) begin
            st_nxt  = cpre_pkg::ST_MACK;
            bit_nxt = '0;
            drv_nxt = 1'b0;
          end else begin
            bit_nxt = bit_r + 4'h1;
            sh_nxt  = {sh_r[6:0], 1'b0};
            drv_nxt = ~sh_r[6];
          end
        end
        cpre_pkg::ST_MACK: begin
          if (scl_rise)
            ack_nxt = ~sda_s;
          else if (scl_fall) begin
            if (ack_r) begin
              st_nxt  = cpre_pkg::ST_TX;
              sh_nxt  = nb;
              drv_nxt = ~nb[7];
              lsb_nxt = ~lsb_r;
            end else begin
              st_nxt  = cpre_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // bus engine registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r  <= cpre_pkg::ST_IDLE;
      by_r  <= cpre_pkg::BY_ADDR;
      bit_r <= '0;
      sh_r  <= '0;
      msb_r <= '0;
      ptr_r <= cpre_pkg::PTR_SETUP;
      rd_r  <= '0;
      rw_r  <= 1'b0;
      drv_r <= 1'b0;
      lsb_r <= 1'b0;
      ack_r <= 1'b0;
      tmo_r <= '0;
    end else begin
      st_r  <= st_nxt;
      by_r  <= by_nxt;
      bit_r <= bit_nxt;
      sh_r  <= sh_nxt;
      msb_r <= msb_nxt;
      ptr_r <= ptr_nxt;
      rd_r  <= rd_nxt;
      rw_r  <= rw_nxt;
      drv_r <= drv_nxt;
      lsb_r <= lsb_nxt;
      ack_r <= ack_nxt;
      tmo_r <= tmo_nxt;
    end
  end

  //------------------------------------------------------------
  // writable registers
  //------------------------------------------------------------
  // result pointers take the write and acknowledge, nothing stored
  always_comb begin
    setup_nxt = setup_r;
    scale_nxt = scale_r;
    set_nxt   = set_r;
    if (wr_go && ptr_r == cpre_pkg::PTR_SETUP)            // [R22]
      setup_nxt = {msb_r, sh_r};
    if (wr_go && ptr_r == cpre_pkg::PTR_SCALE) begin
      scale_nxt = {msb_r, sh_r};
      set_nxt   = 1'b1;                                   // [R6]
    end
  end

  // volatile; defaults come back on every reset
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      setup_r <= cpre_pkg::SETUP_RST;                     // [R8] [R9]
      scale_r <= cpre_pkg::ZERO_RST;
      set_r   <= 1'b0;                                    // [R7]
    end else begin
      setup_r <= setup_nxt;
      scale_r <= scale_nxt;
      set_r   <= set_nxt;
    end
  end

  assign res.conv_done = conv_done_i;
  assign res.shunt_in  = shunt_code_i;
  assign res.rail_in   = rail_code_i;
  assign res.scale     = scale_r;
  assign res.scale_set = set_r;

  cpre_calc u_calc (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .res     (res.engine)
  );

  // pins only pull low; the clock line is never driven
  assign sda_o      = 1'b0;                               // [R18]
  assign sda_oe_n_o = ~drv_r;
  assign scl_o      = 1'b0;                               // [R10]
  assign scl_oe_n_o = 1'b1;
  assign setup_o    = setup_r;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  ack_drive_a: assert property (                               // [R13]
    st_r == cpre_pkg::ST_ACK |-> !sda_oe_n_o && !sda_o)
    else $error("no low drive during acknowledge");
  open_drain_a: assert property (!sda_o && !scl_o && scl_oe_n_o) // [R18]
    else $error("pin driven high or clock driven");
  start_rx_a: assert property (                                // [R11]
    start_det |=> st_r == cpre_pkg::ST_RX && bit_r == 4'h0
      && sda_oe_n_o)
    else $error("start not taken");
  stop_idle_a: assert property (                               // [R16]
    stop_det && !start_det |=> st_r == cpre_pkg::ST_IDLE && sda_oe_n_o)
    else $error("stop not taken");
  stall_rel_a: assert property (                               // [R17]
    tmo_hit && !start_det |=> st_r == cpre_pkg::ST_IDLE && sda_oe_n_o)
    else $error("stall not released");
  ro_hold_a: assert property (                                 // [R22]
    !(wr_go && (ptr_r == cpre_pkg::PTR_SETUP
      || ptr_r == cpre_pkg::PTR_SCALE)) |=>
      $stable(setup_r) && $stable(scale_r))
    else $error("register changed without its write");
  scl_high_a: assert property (                                // [R14]
    st_r == cpre_pkg::ST_TX && scl_s && scl_d && !start_det && !stop_det
      && !tmo_hit |=> $stable(drv_r))
    else $error("data changed while clock high");
  read_c: cover property (st_r == cpre_pkg::ST_MACK && scl_fall && ack_r);
  write_c: cover property (wr_go && ptr_r == cpre_pkg::PTR_SCALE);
  stall_c: cover property (tmo_hit);
endmodule // cpre_top
`default_nettype wire

/* cpre_bus_master.sv */
// two-wire bus master model that drives the monitor's bus pins
`timescale 1ns/100ps
`default_nettype none
module cpre_bus_master (
  // clock of the bench
  input  wire logic clk_i,
  // wired line levels seen on the bus
  input  wire logic sda_i,
  // open-drain drives, 1 = released to the pull-up
  output logic      scl_o,
  output logic      sda_o
);
  // the bus sits released until a frame starts; the clock stands still
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  //------------------------------------------------------------------
  // bit timing: 8 clk per bus clock period, 320 ns
  //------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // start or repeated start from idle or from clock low
  task automatic start_cond();
    tick(2);
    sda_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
  endtask

  // stop from clock low
  task automatic stop_cond();
    tick(2);
    sda_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b1;
    tick(4);
  endtask

  // data changes only in the middle of clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_o <= b;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    r = sda_i;
    tick(2);
    scl_o <= 1'b0;
  endtask

  // eight bits msb first, then the slave's acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // eight bits from the slave, then ack (last = 0) or nack (last = 1)
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule // cpre_bus_master
`default_nettype wire

/* cpre_top_test.sv */
// self-checking bench of the current/power result engine top
`timescale 1ns/100ps
`default_nettype none
module cpre_top_test;
  localparam int TMO = 200;
  typedef struct packed {
    logic [15:0] shunt, rail, scale, cur, pwr, rail_rd;
  } cpre_row_t;

  logic clk_i, arst_n_i, conv_done_i, scl_drv, sda_drv;
  logic [15:0] shunt_code_i, rail_code_i;
  wire logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o;
  wire logic [15:0] setup_o;
  wire logic scl_line, sda_line;
  int n_mismatch = 0;
  int compares = 0;
  logic [15:0] v;
  logic ack;
  int k;
  // shunt, rail, scale, then current, power and rail read back
  cpre_row_t rows [5] = '{
    '{16'h1f40, 16'h2570, 16'h0a00, 16'h2710, 16'h12b8, 16'h2570},
    '{16'he0c0, 16'ha570, 16'h0a00, 16'hd8f0, 16'h12b8, 16'h2570},
    '{16'hf448, 16'h7fff, 16'h0001, 16'hffff, 16'h0001, 16'h7fff},
    '{16'h0003, 16'h1234, 16'h0001, 16'h0000, 16'h0000, 16'h1234},
    '{16'h7fff, 16'h4e20, 16'h0800, 16'h7fff, 16'h7fff, 16'h4e20}};

  // wired-and lines with pull-ups; the device only ever pulls low
  assign scl_line = scl_drv & (scl_oe_n_o | scl_o);
  assign sda_line = sda_drv & (sda_oe_n_o | sda_o);

  cpre_top #(.TMO_CYCLES(TMO)) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i),
    .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .shunt_code_i(shunt_code_i), .rail_code_i(rail_code_i),
    .conv_done_i(conv_done_i), .setup_o(setup_o));

  cpre_bus_master u_mst (
    .clk_i(clk_i), .sda_i(sda_line), .scl_o(scl_drv), .sda_o(sda_drv));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  //------------------------------------------------------------------
  // compare and report
  //------------------------------------------------------------------
  task automatic chk16(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  //------------------------------------------------------------------
  // bus and converter transactions
  //------------------------------------------------------------------
  // address, pointer and the word high byte first, each acknowledged
  task automatic reg_write(input logic [7:0] p, input logic [15:0] d);
    u_mst.start_cond();
    u_mst.wr_byte({cpre_pkg::DEV_ADDR, 1'b0}, ack);
    chk1("addr ack", 1'b1, ack);
    u_mst.wr_byte(p, ack);
    chk1("ptr ack", 1'b1, ack);
    u_mst.wr_byte(d[15:8], ack);
    chk1("msb ack", 1'b1, ack);
    u_mst.wr_byte(d[7:0], ack);
    chk1("lsb ack", 1'b1, ack);
    u_mst.stop_cond();
  endtask

  // pointer write, repeated start, then two bytes high byte first
  task automatic reg_read(input logic [7:0] p, output logic [15:0] d);
    u_mst.start_cond();
    u_mst.wr_byte({cpre_pkg::DEV_ADDR, 1'b0}, ack);
    u_mst.wr_byte(p, ack);
    u_mst.start_cond();
    u_mst.wr_byte({cpre_pkg::DEV_ADDR, 1'b1}, ack);
    chk1("read addr ack", 1'b1, ack);
    u_mst.rd_byte(1'b0, d[15:8]);
    u_mst.rd_byte(1'b1, d[7:0]);
    u_mst.stop_cond();
  endtask

  task automatic convert(input logic [15:0] s, r);
    @(posedge clk_i);
    shunt_code_i <= s;
    rail_code_i  <= r;
    conv_done_i  <= 1'b1;
    @(posedge clk_i);
    conv_done_i  <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // reset held 8 cycles; the bus waits well past the synchroniser
  task automatic do_reset();
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask

  //------------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------------
  initial begin
    arst_n_i     <= 1'b0;
    conv_done_i  <= 1'b0;
    shunt_code_i <= 16'h0000;
    rail_code_i  <= 16'h0000;
    do_reset();
    chk16("setup pin", cpre_pkg::SETUP_RST, setup_o);
    reg_read(cpre_pkg::PTR_SETUP, v);
    chk16("setup reg", cpre_pkg::SETUP_RST, v);
    // ordinary cases: scale, one conversion, all results read back
    foreach (rows[i]) begin
      reg_write(cpre_pkg::PTR_SCALE, rows[i].scale);
      convert(rows[i].shunt, rows[i].rail);
      reg_read(cpre_pkg::PTR_SCALE, v);
      chk16("scale", rows[i].scale, v);
      reg_read(cpre_pkg::PTR_SHUNT, v);
      chk16("shunt", rows[i].shunt, v);
      reg_read(cpre_pkg::PTR_RAIL, v);
      chk16("rail", rows[i].rail_rd, v);
      reg_read(cpre_pkg::PTR_CURRENT, v);
      chk16("current", rows[i].cur, v);
      reg_read(cpre_pkg::PTR_POWER, v);
      chk16("power", rows[i].pwr, v);
      chk1("clock released", 1'b1, scl_oe_n_o);
      chk1("clock drive low", 1'b0, scl_o);
      chk1("data drive low", 1'b0, sda_o);
    end
    // a setup write shows on the pin, then a reset restores defaults
    reg_write(cpre_pkg::PTR_SETUP, 16'h0123);
    chk16("setup written", 16'h0123, setup_o);
    do_reset();
    chk16("setup after reset", cpre_pkg::SETUP_RST, setup_o);
    convert(16'h1f40, 16'h2570);
    reg_read(cpre_pkg::PTR_CURRENT, v);
    chk16("unscaled current", 16'h0000, v);
    reg_read(cpre_pkg::PTR_POWER, v);
    chk16("unscaled power", 16'h0000, v);
    reg_read(cpre_pkg::PTR_RAIL, v);
    chk16("unscaled rail", 16'h2570, v);
    // a scale write alone leaves the results until the next conversion
    reg_write(cpre_pkg::PTR_SCALE, 16'h0a00);
    reg_read(cpre_pkg::PTR_CURRENT, v);
    chk16("current before conversion", 16'h0000, v);
    // result registers acknowledge writes and keep their value
    reg_write(cpre_pkg::PTR_CURRENT, 16'h5555);
    reg_read(cpre_pkg::PTR_CURRENT, v);
    chk16("current after write", 16'h0000, v);
    reg_read(8'h07, v);
    chk16("unmapped read", 16'h0000, v);
    // foreign address is not acknowledged
    u_mst.start_cond();
    u_mst.wr_byte({7'h41, 1'b0}, ack);
    chk1("foreign ack", 1'b0, ack);
    u_mst.stop_cond();
    // stall mid read while the device pulls data low for setup bit 15
    u_mst.start_cond();
    u_mst.wr_byte({cpre_pkg::DEV_ADDR, 1'b0}, ack);
    u_mst.wr_byte(cpre_pkg::PTR_SETUP, ack);
    u_mst.start_cond();
    u_mst.wr_byte({cpre_pkg::DEV_ADDR, 1'b1}, ack);
    u_mst.tick(10);
    chk1("stall drive", 1'b0, sda_oe_n_o);
    u_mst.tick(TMO - 30);
    chk1("early release", 1'b0, sda_oe_n_o);
    k = 0;
    while (sda_oe_n_o !== 1'b1 && k < 60) begin
      @(posedge clk_i);
      k++;
    end
    chk1("timeout release", 1'b1, sda_oe_n_o);
    // a bus that was never let go is useless for the last read
    if (k < 60) begin
      u_mst.stop_cond();
      reg_read(cpre_pkg::PTR_SETUP, v);
      chk16("setup after stall", cpre_pkg::SETUP_RST, v);
    end
    conclude();
  end
endmodule // cpre_top_test
`default_nettype wire
